//--- logic/dmsc_stall_ctrl.sv
// dmsc_stall_ctrl: refresh threshold and cpu stop registers with stall logic
// assumes: fifo levels, read pulses and pixel clock counts are on i_ref_clk
`timescale 1ns/1ps

module dmsc_stall_ctrl (
  // clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst,
  // indexed register port
  input  wire dmsc_pkg::dmsc_io_s   i_io,
  output logic [7:0]                o_rdata,
  // enables from other extension registers
  input  wire logic                 i_ext_seq_control_a_en,
  input  wire logic                 i_ext_seq_control_b_en,
  input  wire logic                 i_test_mode,
  // display clients
  input  wire logic                 i_refresh_fifo_read,
  input  wire dmsc_pkg::dmsc_fifo_s i_fifo,
  input  wire logic [17:0]          i_video_test_bus_group,
  // cpu cycle logic, refresh request and test bus
  input  wire logic                 i_cpu_cycle_active,
  output logic                      o_cpu_hold,
  output logic                      o_cpu_abort,
  output logic                      o_refresh_req,
  output logic [17:0]               o_test_bus
);

  logic [7:0]  thresh_reg;
  logic [7:0]  stop_reg;
  logic [7:0]  rdata_reg;
  logic [7:0]  rdata_next;
  logic        hold_reg;
  logic        abort_reg;
  logic [17:0] test_reg;
  logic [17:0] test_next;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if ((dmsc_pkg::THR_MSB - dmsc_pkg::THR_LSB + 1 != $bits(dmsc_pkg::THR_DEFAULT)) ||
      (dmsc_pkg::CRT_MSB - dmsc_pkg::CRT_LSB + 1 != $bits(dmsc_pkg::CRT_OFF)))
  begin : g_field_check
    $error("dmsc_stall_ctrl: field layout does not match field constants");
  end

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire sel_thr  = i_io.index == dmsc_pkg::IDX_REFRESH_THRESH;
  wire sel_stop = i_io.index == dmsc_pkg::IDX_CPU_STOP;
  assign rdata_next = !i_io.rd ? rdata_reg :
                      sel_thr  ? (thresh_reg & dmsc_pkg::THRESH_RD_MASK) :
                      sel_stop ? stop_reg : 8'h00;

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      thresh_reg <= dmsc_pkg::THRESH_RST;
      stop_reg   <= dmsc_pkg::CPU_STOP_RST;
      rdata_reg  <= 8'h00;
    end
    else
    begin
      if (i_io.wr && sel_thr)
        thresh_reg <= i_io.wdata & dmsc_pkg::THRESH_RD_MASK;
      if (i_io.wr && sel_stop)
        stop_reg <= i_io.wdata;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  wire       stop_en  = thresh_reg[dmsc_pkg::STOP_EN_BIT];
  wire       test_sel = thresh_reg[dmsc_pkg::TEST_SEL_BIT];
  wire [3:0] thr_prog = thresh_reg[dmsc_pkg::THR_MSB:dmsc_pkg::THR_LSB];
  wire       hfa_stop = stop_reg[dmsc_pkg::HFA_BIT];
  wire [1:0] crt_stop = stop_reg[dmsc_pkg::CRT_MSB:dmsc_pkg::CRT_LSB];
  wire       vp_stop  = stop_reg[dmsc_pkg::VPORT_BIT];
  wire [3:0] vw_stop  = stop_reg[dmsc_pkg::VW_MSB:dmsc_pkg::VW_LSB];

  // ----------------------------------------------------------------
  // refresh threshold
  // ----------------------------------------------------------------
  wire       thr_use   = i_ext_seq_control_a_en && i_ext_seq_control_b_en;
  wire [3:0] thr_limit = (!thr_use || thr_prog == dmsc_pkg::THR_ZERO) ?
                         dmsc_pkg::THR_DEFAULT : thr_prog;

  dmsc_read_counter #(.CW(4)) u_refresh_count (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_read    (i_refresh_fifo_read),
    .i_limit   (thr_limit),
    .o_req     (o_refresh_req),
    .o_count   ()
  );

  // ----------------------------------------------------------------
  // stop conditions, levels compared as level + k >= n
  // ----------------------------------------------------------------
  wire [5:0] hfa_sum = 6'(i_fifo.hfa_empty) + 6'd1;
  wire [5:0] crt_sum = 6'(i_fifo.crt_empty) + 6'(crt_stop);
  wire [5:0] vp_sum  = 6'(i_fifo.vport_filled) + 6'd1;
  wire hfa_hit = hfa_stop && hfa_sum >= 6'(i_fifo.hfa_thresh);
  wire crt_hit = crt_stop != dmsc_pkg::CRT_OFF && crt_sum >= 6'(thr_limit);
  wire vp_hit  = vp_stop && vp_sum >= 6'(i_fifo.vport_thresh);
  wire vw_hit  = vw_stop != dmsc_pkg::VW_OFF &&
                 i_fifo.vw_clocks_to_req <= 8'(vw_stop);
  wire stop_active = stop_en && (hfa_hit || crt_hit || vp_hit || vw_hit);

  assign test_next = (i_test_mode && test_sel) ? i_video_test_bus_group : 18'h00000;

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      hold_reg  <= 1'b0;
      abort_reg <= 1'b0;
      test_reg  <= 18'h00000;
    end
    else
    begin
      hold_reg  <= stop_active;
      abort_reg <= stop_active && i_cpu_cycle_active;
      test_reg  <= test_next;
    end
  end

  assign o_rdata     = rdata_reg;
  assign o_cpu_hold  = hold_reg;
  assign o_cpu_abort = abort_reg;
  assign o_test_bus  = test_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  // cpu stop enable and abort
  a_abort_needs_hold: assert property (
    stop_en && i_cpu_cycle_active && vw_hit |=> o_cpu_abort && o_cpu_hold)
    else $error("ongoing cpu cycle not aborted");
  a_abort_idle_cpu: assert property (
    !i_cpu_cycle_active |=> !o_cpu_abort)
    else $error("abort raised with no cpu cycle");
  a_hold_no_cause: assert property (
    stop_en && !hfa_stop && crt_stop == 2'h0 && !vp_stop && vw_stop == 4'h0
    |=> !o_cpu_hold)
    else $error("cpu held with no stop control set");
  a_disabled_no_hold: assert property (
    !stop_en |=> !o_cpu_hold && !o_cpu_abort)
    else $error("cpu held while stop disabled");

  // test bus routing
  a_test_route_on: assert property (
    i_test_mode && test_sel |=> o_test_bus == $past(i_video_test_bus_group))
    else $error("test bus not routed");
  a_test_route_off: assert property (
    !(i_test_mode && test_sel) |=> o_test_bus == 18'h00000)
    else $error("test bus driven while not selected");

  // refresh threshold
  a_thr_ignored: assert property (
    !thr_use |-> thr_limit == 4'hA)
    else $error("threshold used while disabled");
  a_thr_used: assert property (
    thr_use && thr_prog != 4'h0 |-> thr_limit == thr_prog)
    else $error("programmed threshold not used");
  a_req_single: assert property (
    o_refresh_req |=> !o_refresh_req)
    else $error("refresh request longer than one cycle");
  a_zero_as_ten: assert property (
    thr_use && thr_prog == 4'h0 |-> thr_limit == 4'hA)
    else $error("zero threshold not ten");
  a_fifteen_reads: assert property (
    thr_use && thr_prog == 4'hF |-> thr_limit == 4'hF)
    else $error("all ones threshold not fifteen");
  a_thirteen_reads: assert property (
    thr_use && thr_prog == 4'hD |-> thr_limit == 4'hD)
    else $error("1101 threshold not thirteen");

  // stop conditions
  a_hfa_stop_hold: assert property (
    stop_en && hfa_stop &&
    (6'(i_fifo.hfa_empty) + 6'd1 >= 6'(i_fifo.hfa_thresh)) |=> o_cpu_hold)
    else $error("half-frame stop missed");
  a_crt_field_off: assert property (
    stop_en && crt_stop == 2'h0 && !hfa_hit && !vp_hit && !vw_hit |=> !o_cpu_hold)
    else $error("zero refresh field held cpu");
  a_crt_one_hold: assert property (
    stop_en && crt_stop == 2'h1 &&
    6'(i_fifo.crt_empty) + 6'd1 >= 6'(thr_limit) |=> o_cpu_hold)
    else $error("refresh stop one level ahead missed");
  a_crt_two_hold: assert property (
    stop_en && crt_stop == 2'h2 &&
    6'(i_fifo.crt_empty) + 6'd2 >= 6'(thr_limit) |=> o_cpu_hold)
    else $error("refresh stop two levels ahead missed");
  a_crt_stop_hold: assert property (
    stop_en && crt_stop == 2'h3 &&
    6'(i_fifo.crt_empty) + 6'd3 >= 6'(thr_limit) |=> o_cpu_hold)
    else $error("refresh stop missed");
  a_vport_stop_hold: assert property (
    stop_en && vp_stop &&
    6'(i_fifo.vport_filled) + 6'd1 >= 6'(i_fifo.vport_thresh) |=> o_cpu_hold)
    else $error("video port stop missed");
  a_vw_early_hold: assert property (
    stop_en && vw_stop != 4'h0 &&
    i_fifo.vw_clocks_to_req <= 8'(vw_stop) |=> o_cpu_hold)
    else $error("video window stop missed");
  a_vw_zero_off: assert property (
    stop_en && vw_stop == 4'h0 && !hfa_hit && !crt_hit && !vp_hit |=> !o_cpu_hold)
    else $error("zero video window field held cpu");

  c_hold_seen:  cover property (stop_en ##1 o_cpu_hold);
  c_abort_seen: cover property (o_cpu_abort);
  c_req_seen:   cover property (thr_use && thr_prog == 4'hD ##1 o_refresh_req);
  c_test_route: cover property (i_test_mode && test_sel ##1 o_test_bus != 18'h00000);
  c_vw_hold:    cover property (stop_en && vw_hit ##1 o_cpu_hold);

endmodule // dmsc_stall_ctrl

//--- logic/dmsc_pkg.sv
// dmsc_pkg: constants and carriers for the display memory cpu stall control
// assumes: included before every dmsc design file
package dmsc_pkg;

  // ----------------------------------------------------------------
  // register indices on the indexed i/o port
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_REFRESH_THRESH = 8'h33;
  localparam logic [7:0] IDX_CPU_STOP       = 8'h34;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int         THR_LSB          = 0;
  localparam int         THR_MSB          = 3;
  localparam int         TEST_SEL_BIT     = 4;
  localparam int         STOP_EN_BIT      = 5;
  localparam int         VW_LSB           = 0;
  localparam int         VW_MSB           = 3;
  localparam int         VPORT_BIT        = 4;
  localparam int         CRT_LSB          = 5;
  localparam int         CRT_MSB          = 6;
  localparam int         HFA_BIT          = 7;
  localparam logic [7:0] THRESH_RST       = 8'h00;
  localparam logic [7:0] CPU_STOP_RST     = 8'h00;
  localparam logic [7:0] THRESH_RD_MASK   = 8'h3F;

  // ----------------------------------------------------------------
  // refresh read counting and stop field off values
  // ----------------------------------------------------------------
  localparam logic [3:0] THR_ZERO         = 4'h0;
  localparam logic [3:0] THR_DEFAULT      = 4'hA;
  localparam logic [3:0] VW_OFF           = 4'h0;
  localparam logic [1:0] CRT_OFF          = 2'h0;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] index;
    logic [7:0] wdata;
  } dmsc_io_s;

  typedef struct packed {
    logic [4:0] hfa_empty;
    logic [3:0] hfa_thresh;
    logic [4:0] crt_empty;
    logic [4:0] vport_filled;
    logic [3:0] vport_thresh;
    logic [7:0] vw_clocks_to_req;
  } dmsc_fifo_s;

endpackage

//--- logic/dmsc_read_counter.sv
// dmsc_read_counter: counts refresh fifo reads, pulses a request at the limit
// assumes: reads are one-cycle pulses on the same clock, limit is nonzero
`timescale 1ns/1ps
module dmsc_read_counter #(
  parameter int CW = 4
) (
  // clock and reset
  input  wire logic          i_ref_clk,
  input  wire logic          i_rst,
  // counting
  input  wire logic          i_read,
  input  wire logic [CW-1:0] i_limit,
  output logic               o_req,
  output logic [CW-1:0]      o_count
);

  // limits up to fifteen need four bits
  if (CW < 4)
  begin : g_cw_check
    $error("dmsc_read_counter: CW below 4");
  end

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic          req_reg;
  logic          req_next;
  logic          at_limit;

  // ----------------------------------------------------------------
  // count logic
  // ----------------------------------------------------------------
  assign at_limit = (cnt_reg + CW'(1)) >= i_limit;
  assign cnt_next = !i_read ? cnt_reg : (at_limit ? '0 : cnt_reg + CW'(1));
  assign req_next = i_read && at_limit;

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_reg <= '0;
      req_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      req_reg <= req_next;
    end
  end

  assign o_req   = req_reg;
  assign o_count = cnt_reg;

  a_req_at_limit: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    i_read && (cnt_reg + CW'(1) == i_limit) |=> o_req && cnt_reg == '0)
    else $error("refresh request missing at read limit");

endmodule // dmsc_read_counter

//--- test/dmsc_cpu_model.sv
// dmsc_cpu_model: host cpu cycle logic facing the stall outputs
// assumes: demand comes from the bench, hold and abort from the stall block
`timescale 1ns/1ps
module dmsc_cpu_model (
  // clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  // demand and stall
  input  wire logic i_want,
  input  wire logic i_cpu_hold,
  input  wire logic i_cpu_abort,
  // cycle state
  output logic      o_cpu_cycle_active
);
  logic active_next;
  // abort ends a cycle, hold keeps a new one from starting
  assign active_next = i_cpu_abort ? 1'b0 :
                       (o_cpu_cycle_active ? i_want : (i_want && !i_cpu_hold));
  always_ff @(posedge i_ref_clk or posedge i_rst)
    if (i_rst)
      o_cpu_cycle_active <= 1'b0;
    else
      o_cpu_cycle_active <= active_next;
endmodule // dmsc_cpu_model

//--- test/dmsc_stall_ctrl_tb_top.sv
// dmsc_stall_ctrl_tb_top: self-checking bench for the stall control block
// assumes: dmsc_pkg compiled first, cpu model beside the design
`timescale 1ns/1ps
module dmsc_stall_ctrl_tb_top;
  logic                 i_ref_clk;
  logic                 i_rst;
  dmsc_pkg::dmsc_io_s   io;
  dmsc_pkg::dmsc_fifo_s fifo;
  logic [7:0]           rdata;
  logic [7:0]           r33;
  logic [7:0]           r34;
  logic                 en_a, en_b, tmode, rd_pulse, want, active, hold, abort, req;
  logic [17:0]          grp, tbus;
  logic [3:0]           thr_tab [5] = '{4'h0, 4'hA, 4'hD, 4'hF, 4'hD};
  int                   n_tab [5] = '{10, 10, 13, 15, 10};
  int                   n_mismatch, n_compared, n_req, cyc, gap;

  dmsc_stall_ctrl i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_io(io), .o_rdata(rdata),
    .i_ext_seq_control_a_en(en_a), .i_ext_seq_control_b_en(en_b), .i_test_mode(tmode),
    .i_refresh_fifo_read(rd_pulse), .i_fifo(fifo), .i_video_test_bus_group(grp),
    .i_cpu_cycle_active(active), .o_cpu_hold(hold), .o_cpu_abort(abort),
    .o_refresh_req(req), .o_test_bus(tbus));
  dmsc_cpu_model i_cpu (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_want(want),
    .i_cpu_hold(hold), .i_cpu_abort(abort), .o_cpu_cycle_active(active));

  initial
  begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  task automatic tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // refresh pulses counted, hang cut short
  always @(posedge i_ref_clk)
  begin
    cyc++;
    if (req === 1'b1)
      n_req++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [17:0] got, exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_ref_clk);
    if (n > 0)
      #1;
  endtask
  task automatic wr(input logic [7:0] idx, d);
    io = '{1'b1, 1'b0, idx, d};
    step(1);
    io.wr = 1'b0;
    step(1);
  endtask
  task automatic rd(input logic [7:0] idx, exp);
    io = '{1'b0, 1'b1, idx, 8'h00};
    step(1);
    io.rd = 1'b0;
    step(1);
    chk({10'h000, rdata}, {10'h000, exp}, "read data");
  endtask
  function automatic logic exp_hold();
    int n;
    n = (en_a && en_b && r33[3:0] != 4'h0) ? int'(r33[3:0]) : 10;
    return r33[5] && ((r34[7] && fifo.hfa_empty + 1 >= fifo.hfa_thresh) ||
      (r34[6:5] != 2'h0 && fifo.crt_empty + 0 + r34[6:5] >= n) ||
      (r34[4] && fifo.vport_filled + 1 >= fifo.vport_thresh) ||
      (r34[3:0] != 4'h0 && fifo.vw_clocks_to_req <= r34[3:0]));
  endfunction

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    io = '0; fifo = '0; en_a = 1'b0; en_b = 1'b0; tmode = 1'b0;
    rd_pulse = 1'b0; want = 1'b0; grp = 18'h00000; i_rst = 1'b1;
    void'($urandom(32'h771E6FED));
    repeat (6) @(posedge i_ref_clk);
    #1 i_rst = 1'b0;
    rd(8'h33, 8'h00);
    rd(8'h34, 8'h00);
    rd(8'h35, 8'h00);
    wr(8'h33, 8'hFF);
    rd(8'h33, 8'h3F);
    wr(8'h34, 8'hA5);
    rd(8'h34, 8'hA5);
    $display("test registers done");
    for (int i = 0; i < 5; i++)
    begin
      en_a = (i < 4);
      en_b = 1'b1;
      wr(8'h33, {4'h0, thr_tab[i]});
      n_req = 0;
      for (int k = 0; k < 2 * n_tab[i]; k++)
      begin
        rd_pulse = 1'b1;
        step(1);
        gap = (k >= 2 * n_tab[i] - 2) ? 1 : $urandom_range(0, 2);
        if (gap > 0)
        begin
          rd_pulse = 1'b0;
          step(gap);
        end
        if (k == 2 * n_tab[i] - 2)
        begin
          step(3);
          chk(18'(n_req), 18'd1, "requests before last read");
        end
      end
      step(3);
      chk(18'(n_req), 18'd2, "requests per two periods");
    end
    $display("test refresh threshold done");
    want = 1'b1;
    for (int i = 0; i < 200; i++)
    begin
      r33 = 8'($urandom) & 8'h2F;
      r34 = 8'($urandom);
      {en_a, en_b} = 2'($urandom);
      fifo = dmsc_pkg::dmsc_fifo_s'(31'($urandom));
      fifo.vw_clocks_to_req = 8'($urandom_range(0, 20));
      wr(8'h33, r33);
      wr(8'h34, r34);
      step(4);
      chk({17'h0, hold}, {17'h0, exp_hold()}, "cpu hold");
      chk({17'h0, active}, {17'h0, !exp_hold()}, "cpu cycle");
    end
    fifo = '0;
    wr(8'h33, 8'h00);
    wr(8'h34, 8'h01);
    step(3);
    chk({17'h0, active}, 18'h00001, "cpu runs with stop off");
    wr(8'h33, 8'h20);
    chk({17'h0, abort}, 18'h00001, "cpu abort raised");
    step(3);
    chk({17'h0, abort}, 18'h00000, "cpu abort ended");
    chk({17'h0, active}, 18'h00000, "cpu cycle cut");
    $display("test cpu stop done");
    want = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      tmode = i[0];
      wr(8'h33, {3'h0, i[1], 4'h0});
      grp = 18'($urandom);
      step(2);
      chk(tbus, (i == 3) ? grp : 18'h00000, "test bus");
    end
    $display("test test bus done");
    tally_and_finish();
  end
endmodule // dmsc_stall_ctrl_tb_top
